// ==== dcf_defines.svh ====
`ifndef DCF_DEFINES_SVH
`define DCF_DEFINES_SVH

// word and storage geometry
`define DCF_WIDTH        18
`define DCF_AW           9
`define DCF_PW           10
`define DCF_DEPTH        10'h200
`define DCF_LAST_ADDR    9'h1FF
`define DCF_ADDR_STEP    9'h001
`define DCF_PTR_STEP     10'h001
`define DCF_PTR_RST      10'h000
`define DCF_CNT_EMPTY    10'h000

// parity bit positions and the data bytes they cover
`define DCF_PAR_LO       8
`define DCF_PAR_HI       17
`define DCF_BYTE_LO      7:0
`define DCF_BYTE_HI      16:9

// flag thresholds in words of occupancy
`define DCF_HALF_LEVEL   10'h100
`define DCF_AEMPTY_LEVEL 10'h008
`define DCF_AFULL_LEVEL  10'h1F8

// parity mode codes
`define DCF_PMODE_OFF    2'h0
`define DCF_PMODE_GEN    2'h1
`define DCF_PMODE_CHECK  2'h2

`endif

// ==== dcf_pkg.sv ====
`include "dcf_defines.svh"

package dcf_pkg;

  // parity configuration of bits 8 and 17
  typedef enum logic [1:0] {
    DCF_PAR_OFF   = `DCF_PMODE_OFF,
    DCF_PAR_GEN   = `DCF_PMODE_GEN,
    DCF_PAR_CHECK = `DCF_PMODE_CHECK
  } dcf_parity_mode_t;

  typedef logic [`DCF_WIDTH-1:0] dcf_word_t;

  // whole state of the port logic
  typedef struct packed {
    logic [2:0]      wclk_s;
    logic [2:0]      rclk_s;
    logic [1:0]      wen_n_s;
    logic [1:0]      ren_n_s;
    logic [1:0]      mr_s;
    logic [1:0][`DCF_WIDTH-1:0] din_s;
    logic [`DCF_PW-1:0] wptr;
    logic [`DCF_PW-1:0] rptr;
    logic            empty;
    logic            aempty;
    logic            full;
    logic            afull;
    logic            half;
    dcf_word_t       prog;
    dcf_word_t       dout;
    logic            ef_n;
    logic            hf_n;
    logic            pin;
  } dcf_state_t;

  // storage array state
  typedef struct packed {
    logic [`DCF_DEPTH-1:0][`DCF_WIDTH-1:0] cells;
  } dcf_mem_state_t;

  // even parity over one data byte
  function automatic logic dcf_parity(input logic [7:0] b);
    return ^b;
  endfunction

endpackage

// ==== dcf_mem_if.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dcf_defines.svh"

interface dcf_mem_if;
  logic                 we;
  logic [`DCF_AW-1:0]   waddr;
  dcf_pkg::dcf_word_t   wdata;
  logic [`DCF_AW-1:0]   raddr;
  dcf_pkg::dcf_word_t   rdata;

  modport ctrl  (output we, output waddr, output wdata, output raddr, input rdata);
  modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

`default_nettype wire

// ==== dcf_mem.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dcf_defines.svh"

module dcf_mem (
  input  wire logic    i_core_clk,
  input  wire logic    i_rst,
  input  wire logic    i_clk_en,
  dcf_mem_if.store     mem
);
  import dcf_pkg::*;

  dcf_mem_state_t st;
  dcf_mem_state_t st_nxt;

  // one write port, read is a plain index into the flops
  always_comb begin
    st_nxt = st;
    if (mem.we) begin
      st_nxt.cells[mem.waddr] = mem.wdata;
    end
  end

  assign mem.rdata = st.cells[mem.raddr];

  // state register, frozen while the clock enable is low
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      st <= '0;
    end else if (i_clk_en) begin
      st <= st_nxt;
    end
  end

endmodule // dcf_mem

`default_nettype wire

// ==== dcf_port.sv ====
// Functional notes
// - write edge stores input word when not full
// - master reset write edge loads programming register
// - parity generation replaces input bits 8 and 17
// - read edge presents next word when not empty
// - master reset read edge outputs programming register
// - bits 8/17 are data, parity or error
// - write enable gates write edges in all modes
// - read enable gates read edges in all modes
// - write enable low active; write edge updates full-side flags
// - read enable low active; read edge updates empty-side flags
// - half-full flag timed by write edges
// - empty meaning by read, full by write
// - dual pin: almost flags, or cascade out
// - three flag pins encode six fill states
// - flags hold each new state one clock
`timescale 1ns/1ps
`default_nettype none
`include "dcf_defines.svh"

module dcf_port (
  input  wire logic                   i_core_clk,
  input  wire logic                   i_rst,
  input  wire logic                   i_clk_en,
  input  wire logic                   i_write_clock,
  input  wire logic                   i_read_clock,
  input  wire logic                   i_write_enable_n,
  input  wire logic                   i_read_enable_n,
  input  wire logic                   i_master_reset,
  input  wire logic [`DCF_WIDTH-1:0]  i_data,
  input  wire dcf_pkg::dcf_parity_mode_t i_parity_mode,
  input  wire logic                   i_cascade_en,
  output logic      [`DCF_WIDTH-1:0]  o_data,
  output logic                        o_empty_full_n,
  output logic                        o_half_full_flag_n,
  output logic                        o_almost_flag_or_cascade_out
);
  import dcf_pkg::*;

  dcf_state_t         st;
  dcf_state_t         st_nxt;
  logic               wedge;
  logic               redge;
  logic               mr;
  logic               wr_go;
  logic               rd_go;
  logic               mem_we;
  logic               mem_re;
  logic               xo_pulse;
  logic [`DCF_PW-1:0] occ;
  logic [`DCF_PW-1:0] occ_nxt;
  dcf_word_t          wr_word;
  dcf_word_t          rd_word;

  dcf_mem_if mem_bus ();

  dcf_mem u_mem (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_clk_en   (i_clk_en),
    .mem        (mem_bus.store)
  );

  // edges and levels seen only after the second sync flop
  assign wedge = st.wclk_s[1] & ~st.wclk_s[2];
  assign redge = st.rclk_s[1] & ~st.rclk_s[2];
  assign mr    = st.mr_s[1];
  assign occ   = st.wptr - st.rptr;
  assign wr_go = wedge & ~st.wen_n_s[1];
  assign rd_go = redge & ~st.ren_n_s[1];

  // real occupancy gates access, so a stale flag never overruns the store
  assign mem_we = wr_go & ~mr & (occ != `DCF_DEPTH);
  assign mem_re = rd_go & ~mr & (occ != `DCF_CNT_EMPTY);

  // one-cycle low marker when the last location fills in cascade use
  assign xo_pulse = mem_we & (st.wptr[`DCF_AW-1:0] == `DCF_LAST_ADDR);

  // parity generation overrides the two parity positions on entry
  always_comb begin
    wr_word = st.din_s[1];
    if (i_parity_mode == DCF_PAR_GEN) begin
      wr_word[`DCF_PAR_LO] = dcf_parity(wr_word[`DCF_BYTE_LO]);
      wr_word[`DCF_PAR_HI] = dcf_parity(wr_word[`DCF_BYTE_HI]);
    end
  end

  // check mode turns the stored parity bits into error flags
  always_comb begin
    rd_word = mem_bus.rdata;
    if (i_parity_mode == DCF_PAR_CHECK) begin
      rd_word[`DCF_PAR_LO] = dcf_parity(rd_word[`DCF_BYTE_LO]) ^ rd_word[`DCF_PAR_LO];
      rd_word[`DCF_PAR_HI] = dcf_parity(rd_word[`DCF_BYTE_HI]) ^ rd_word[`DCF_PAR_HI];
    end
  end

  assign mem_bus.we    = mem_we;
  assign mem_bus.waddr = st.wptr[`DCF_AW-1:0];
  assign mem_bus.wdata = wr_word;
  assign mem_bus.raddr = st.rptr[`DCF_AW-1:0];

  // next state: sync chains, pointers, flags, output pins
  always_comb begin
    st_nxt         = st;
    st_nxt.wclk_s  = {st.wclk_s[1:0], i_write_clock};
    st_nxt.rclk_s  = {st.rclk_s[1:0], i_read_clock};
    st_nxt.wen_n_s = {st.wen_n_s[0], i_write_enable_n};
    st_nxt.ren_n_s = {st.ren_n_s[0], i_read_enable_n};
    st_nxt.mr_s    = {st.mr_s[0], i_master_reset};
    st_nxt.din_s   = {st.din_s[0], i_data};
    if (wr_go & mr) begin
      st_nxt.prog = st.din_s[1];
    end
    if (mem_we) begin
      st_nxt.wptr = st.wptr + `DCF_PTR_STEP;
    end
    if (rd_go & mr) begin
      st_nxt.dout = st.prog;
    end else if (mem_re) begin
      st_nxt.dout = rd_word;
      st_nxt.rptr = st.rptr + `DCF_PTR_STEP;
    end
    // master reset empties the store while held
    if (mr) begin
      st_nxt.wptr = `DCF_PTR_RST;
      st_nxt.rptr = `DCF_PTR_RST;
    end
    occ_nxt = st_nxt.wptr - st_nxt.rptr;
    // full side moves only on write edges or master reset, so it holds a whole write period
    if (wedge | mr) begin
      st_nxt.full  = (occ_nxt == `DCF_DEPTH);
      st_nxt.afull = (occ_nxt >= `DCF_AFULL_LEVEL);
      st_nxt.half  = (occ_nxt > `DCF_HALF_LEVEL);
    end
    // empty side moves only on read edges or master reset
    if (redge | mr) begin
      st_nxt.empty  = (occ_nxt == `DCF_CNT_EMPTY);
      st_nxt.aempty = (occ_nxt <= `DCF_AEMPTY_LEVEL);
    end
    // pins: empty/full, half, and the almost or cascade pin
    st_nxt.ef_n = ~(st_nxt.empty | st_nxt.full);
    st_nxt.hf_n = ~st_nxt.half;
    if (i_cascade_en) begin
      st_nxt.pin = ~xo_pulse;
    end else begin
      st_nxt.pin = ~(st_nxt.aempty | st_nxt.afull);
    end
  end

  // state register; reset leaves an empty store
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      st <= '{empty: 1'b1, aempty: 1'b1, hf_n: 1'b1, default: '0};
    end else if (i_clk_en) begin
      st <= st_nxt;
    end
  end

  assign o_data                       = st.dout;
  assign o_empty_full_n               = st.ef_n;
  assign o_half_full_flag_n           = st.hf_n;
  assign o_almost_flag_or_cascade_out = st.pin;

  // accepted write advances the write pointer by one
  chk_write_store: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (i_clk_en & wr_go & ~mr & (occ != `DCF_DEPTH)) |=> (st.wptr == $past(st.wptr) + `DCF_PTR_STEP))
    else $error("accepted write did not advance pointer");

  // programming load takes the raw input word
  chk_prog_load: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (i_clk_en & wr_go & mr) |=> (st.prog == $past(st.din_s[1])))
    else $error("programming register not loaded");

  // a write edge with enable high leaves the store alone
  chk_write_gated: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (i_clk_en & wedge & st.wen_n_s[1] & ~mr) |=> $stable(st.wptr))
    else $error("write taken with enable inactive");

  // accepted read advances pointer and shows the word
  chk_read_pop: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (i_clk_en & rd_go & ~mr & (occ != `DCF_CNT_EMPTY))
      |=> ((st.rptr == $past(st.rptr) + `DCF_PTR_STEP) && (o_data == $past(rd_word))))
    else $error("accepted read did not pop");

  // read under master reset shows the programming register
  chk_prog_read: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (i_clk_en & rd_go & mr) |=> (o_data == $past(st.prog)))
    else $error("programming register not presented");

  // a read edge with enable high leaves the output alone
  chk_read_gated: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (i_clk_en & redge & st.ren_n_s[1] & ~mr) |=> ($stable(st.rptr) && $stable(o_data)))
    else $error("read taken with enable inactive");

  // empty only moves on a read edge or master reset
  chk_empty_owner: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    $changed(st.empty) |-> $past(i_clk_en & (redge | mr)))
    else $error("empty flag moved off a read edge");

  // full and half only move on a write edge or master reset
  chk_full_owner: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    ($changed(st.full) || $changed(st.half)) |-> $past(i_clk_en & (wedge | mr)))
    else $error("full side flag moved off a write edge");

  // pin encoding never shows empty and full together
  chk_flag_code: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    !(st.empty && st.full) && (o_empty_full_n == ~(st.empty | st.full)))
    else $error("illegal flag encoding");

  // pointers never drift apart by more than the depth
  chk_occ_bound: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    occ <= `DCF_DEPTH)
    else $error("occupancy beyond depth");

endmodule // dcf_port

`default_nettype wire

// ==== dcf_peer.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dcf_defines.svh"

// producer and consumer pins; no expansion_in pin exists, so it counts as low
module dcf_peer (
  input  wire logic                  i_core_clk,
  output logic                       o_write_clock,
  output logic                       o_read_clock,
  output logic                       o_write_enable_n,
  output logic                       o_read_enable_n,
  output logic                       o_master_reset,
  output logic [`DCF_WIDTH-1:0]      o_data
);
  // idle pins: clocks low, enables off, standalone wiring
  initial begin
    o_write_clock = 1'b0;
    o_read_clock = 1'b0;
    o_write_enable_n = 1'b1;
    o_read_enable_n = 1'b1;
    o_master_reset = 1'b0;
    o_data = 18'h00000;
  end

  // one clock pulse; pins held 4 core cycles high and low, well above 3
  task automatic strobe(input bit rd, input logic [17:0] d, input logic en_n,
                        input logic mr);
    @(posedge i_core_clk);
    o_data <= d;
    o_master_reset <= mr;
    if (rd) o_read_enable_n <= en_n;
    else o_write_enable_n <= en_n;
    repeat (2) @(posedge i_core_clk);
    if (rd) o_read_clock <= 1'b1;
    else o_write_clock <= 1'b1;
    repeat (4) @(posedge i_core_clk);
    // released data shows the inverse, not a stale copy
    o_read_clock <= 1'b0;
    o_write_clock <= 1'b0;
    o_data <= ~d;
    o_write_enable_n <= 1'b1;
    o_read_enable_n <= 1'b1;
    o_master_reset <= 1'b0;
    repeat (4) @(posedge i_core_clk);
  endtask
endmodule // dcf_peer

`default_nettype wire

// ==== dual_clock_fifo_port_logic_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dcf_defines.svh"

module dual_clock_fifo_port_logic_bench;
  import dcf_pkg::*;
  logic                   i_core_clk;
  logic                   i_rst;
  logic                   wclk, rclk, wen_n, ren_n, mr;
  logic [`DCF_WIDTH-1:0]  din, dout;
  dcf_parity_mode_t       pmode;
  logic                   ef_n, hf_n, alm;
  logic                   casc;
  int                     xo_lows = 0;
  int                     xo_base = 0;
  int                     n_errors = 0;
  int                     comparisons = 0;

  dcf_peer dcf_peer_inst (.i_core_clk(i_core_clk), .o_write_clock(wclk),
    .o_read_clock(rclk), .o_write_enable_n(wen_n), .o_read_enable_n(ren_n),
    .o_master_reset(mr), .o_data(din));

  dcf_port dcf_port_inst (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_clk_en(1'b1),
    .i_write_clock(wclk), .i_read_clock(rclk), .i_write_enable_n(wen_n),
    .i_read_enable_n(ren_n), .i_master_reset(mr), .i_data(din),
    .i_parity_mode(pmode), .i_cascade_en(casc), .o_data(dout),
    .o_empty_full_n(ef_n), .o_half_full_flag_n(hf_n),
    .o_almost_flag_or_cascade_out(alm));

  // 50 MHz core clock
  initial begin
    i_core_clk = 1'b0;
    forever #10 i_core_clk = ~i_core_clk;
  end

  // low cycles of the dual pin in cascade use, sampled mid-cycle where it is settled
  always @(negedge i_core_clk) begin
    if (casc && !alm) xo_lows++;
  end

  task automatic check(input string what, input logic [17:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    if (n_errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic push(input logic [17:0] d, input logic en_n = 1'b0, mr = 1'b0);
    dcf_peer_inst.strobe(1'b0, d, en_n, mr);
  endtask

  task automatic pop(input logic en_n = 1'b0, mr = 1'b0);
    dcf_peer_inst.strobe(1'b1, 18'h2AAAA, en_n, mr);
  endtask

  // a full run is about 11k core cycles; allow a wide margin
  initial begin
    repeat (40000) @(posedge i_core_clk);
    n_errors++;
    give_verdict();
  end

  initial begin
    i_rst = 1'b1;
    pmode = DCF_PAR_OFF;
    casc = 1'b0;
    repeat (12) @(posedge i_core_clk);
    i_rst <= 1'b0;
    check("ef_rst", ef_n, 18'h0);
    check("hf_rst", hf_n, 18'h1);
    check("alm_rst", alm, 18'h0);
    // plain traffic, a disabled write and a disabled read
    push(18'h12345);
    push(18'h3FFFF);
    push(18'h0ABCD, 1'b1);
    pop(); check("rd0", dout, 18'h12345);
    pop(); check("rd1", dout, 18'h3FFFF);
    pop(); check("rd_empty", dout, 18'h3FFFF);
    check("ef_empty", ef_n, 18'h0);
    push(18'h00100);
    pop(1'b1); check("rd_off", dout, 18'h3FFFF);
    pop(); check("rd2", dout, 18'h00100);
    // generated parity replaces bits 8 and 17 at write time
    pmode <= DCF_PAR_GEN;
    push({1'b1, 8'h03, 1'b0, 8'h07});
    pmode <= DCF_PAR_OFF;
    pop(); check("par_gen", dout, {^8'h03, 8'h03, ^8'h07, 8'h07});
    // bad low-byte parity is flagged when read in check mode
    push({1'b0, 8'h03, 1'b0, 8'h07});
    pmode <= DCF_PAR_CHECK;
    pop(); check("par_chk", dout, {1'b0, 8'h03, 1'b1, 8'h07});
    pmode <= DCF_PAR_OFF;
    // programming register path under master reset
    push(18'h1B00D, 1'b0, 1'b1);
    pop(1'b0, 1'b1); check("prog_rd", dout, 18'h1B00D);
    check("prog_rd_mode", dout, 18'h1B00D);
    // fill to the top, watching the almost-empty, half-full and almost-full thresholds
    // the empty side only moves on a read rise, so idle read rises refresh it
    for (int i = 0; i < 512; i++) begin
      if (i == 511) begin
        casc <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        xo_base = xo_lows;
      end
      push(18'(i));
      if (i == 7 || i == 8) pop(1'b1);
      if (i == 7) check("alm_8", alm, 18'h0);
      if (i == 8) check("alm_9", alm, 18'h1);
      if (i == 255) check("hf_256", hf_n, 18'h1);
      if (i == 256) check("hf_257", hf_n, 18'h0);
      if (i == 502) check("alm_503", alm, 18'h1);
      if (i == 503) check("alm_504", alm, 18'h0);
    end
    // cascade pin pulses low once as the last location fills
    check("xo_pulse", 18'(xo_lows - xo_base), 18'h1);
    casc <= 1'b0;
    check("ef_full", ef_n, 18'h0);
    push(18'h3FFFF);
    // drain: order kept, the write at full left no trace
    for (int i = 0; i < 512; i++) begin
      pop();
      check("drain", dout, 18'(i));
      if (i == 0) begin
        push(18'h3FFFF, 1'b1); // idle write rise lets the full side clear
        check("ef_mid", ef_n, 18'h1);
      end
    end
    pop(); check("drain_end", dout, 18'h001FF);
    check("ef_drained", ef_n, 18'h0);
    give_verdict();
  end
endmodule // dual_clock_fifo_port_logic_bench

`default_nettype wire
